//--- inc/msfifo_pkg.sv
// shared stream fifo package: widths, apb map, types.
// assumes a single clock domain and an apb master with 32-bit data.
package msfifo_pkg;

  // ----------------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ERR_W  = 1;
  localparam int CH_W   = 4;
  localparam int MAX_CH = 16;
  localparam int APB_AW = 8;

  // ----------------------------------------------------------------------------
  // apb register offsets (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [APB_AW-1:0] OFF_AF1      = 8'h00;
  localparam logic [APB_AW-1:0] OFF_AF2      = 8'h04;
  localparam logic [APB_AW-1:0] OFF_AE1      = 8'h08;
  localparam logic [APB_AW-1:0] OFF_AE2      = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_INT_STAT = 8'h10;
  localparam logic [APB_AW-1:0] OFF_INT_CLR  = 8'h14;
  localparam logic [APB_AW-1:0] OFF_INT_EN   = 8'h18;
  localparam logic [APB_AW-1:0] OFF_DROP_CNT = 8'h1c;

  // ----------------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------------
  localparam logic [31:0] AF1_RST    = 32'h0000_000c;
  localparam logic [31:0] AF2_RST    = 32'h0000_000e;
  localparam logic [31:0] AE1_RST    = 32'h0000_0004;
  localparam logic [31:0] AE2_RST    = 32'h0000_0002;
  localparam logic [2:0]  INT_EN_RST = 3'h0;

  // ----------------------------------------------------------------------------
  // interrupt status bit positions
  // ----------------------------------------------------------------------------
  localparam int INT_W    = 3;
  localparam int INT_DROP = 0;
  localparam int INT_MISS = 1;
  localparam int INT_AF   = 2;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [CH_W-1:0]   channel;
    logic              sop;
    logic              eop;
    logic [ERR_W-1:0]  error;
  } msfifo_beat_type;

  typedef struct packed {
    logic            valid;
    logic [CH_W-1:0] channel;
    logic [1:0]      data;
  } msfifo_stat_type;

  typedef enum logic [2:0] {
    RQ_IDLE = 3'b000,
    RQ_LOOK = 3'b001,
    RQ_READ = 3'b011,
    RQ_LOAD = 3'b010,
    RQ_SHOW = 3'b110
  } msfifo_rq_type;

endpackage

//--- hw/msfifo_top.sv
// multi-channel stream fifo with all channels in one shared array.
// assumes pclk at 200 MHz, all inputs synchronous to pclk, an apb master for thresholds.
//
// Overview of operation
// - up to sixteen channels, each with its own fixed segment of one storage space
// - each channel's words leave in the order they were accepted
// - all segments live in one array; segment depth is the depth parameter
// - status outputs carry two bits, one symbol, no backpressure, error or packets
// - stream and status ports carry a channel field for sixteen channels
// - software writes and reads one shared set of almost-full and almost-empty levels
// - fill port returns the addressed channel's level one cycle after the read
// - request port inputs are used only when the request parameter is set
// - request address is the channel number
// - at most one word answers each accepted request; one request outstanding at a time
// - requested word appears on the output three cycles after acceptance
// - a packet with error on any beat is discarded whole
// - words are forwarded only once a whole packet of that channel has arrived
// - empty or incomplete channel answers a request with output valid low
// - without request port, strobe stays asserted and channel stays zero
// - without request port only channel zero is reachable
// - each channel's fill is compared with the almost-full levels
// - status walks round-robin, one channel per cycle, k then k plus one
module msfifo_top #(
  parameter int NUM_CH      = 16,
  parameter int DEPTH       = 16,
  parameter int USE_REQUEST = 1
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [msfifo_pkg::APB_AW-1:0]  paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           in_valid,
  input  wire msfifo_pkg::msfifo_beat_type    in_beat,
  output logic                                in_ready,
  output logic                                out_valid,
  output msfifo_pkg::msfifo_beat_type         out_beat,
  input  wire logic                           out_ready,
  input  wire logic                           req_strobe,
  input  wire logic [msfifo_pkg::CH_W-1:0]    req_channel,
  output logic                                req_busy,
  input  wire logic                           fill_read,
  input  wire logic [msfifo_pkg::CH_W-1:0]    fill_channel,
  output logic      [31:0]                    fill_rdata,
  output logic                                fill_rvalid,
  output msfifo_pkg::msfifo_stat_type         af_stat,
  output msfifo_pkg::msfifo_stat_type         ae_stat,
  output logic                                irq
);

  // ----------------------------------------------------------------------------
  // sizes and helpers
  // ----------------------------------------------------------------------------
  localparam int CW = msfifo_pkg::CH_W;
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int SW = CW + AW;
  localparam logic [PW-1:0] ROOM_MAX = PW'(DEPTH - 2);
  localparam logic [CW-1:0] LAST_CH  = CW'(NUM_CH - 1);

  // segment base is the channel number, so segments never overlap
  function automatic logic [SW-1:0] seg_addr(input logic [CW-1:0] ch, input logic [PW-1:0] p);
    seg_addr = {ch, p[AW-1:0]};
  endfunction

  function automatic logic [31:0] widen(input logic [PW-1:0] v);
    widen = {{(32-PW){1'b0}}, v};
  endfunction

  // ----------------------------------------------------------------------------
  // storage and per-channel pointers
  // ----------------------------------------------------------------------------
  msfifo_pkg::msfifo_beat_type mem [NUM_CH*DEPTH];
  logic [PW-1:0]               wr_ptr_r  [NUM_CH];
  logic [PW-1:0]               cmt_ptr_r [NUM_CH];
  logic [PW-1:0]               rd_ptr_r  [NUM_CH];
  logic                        drop_r    [NUM_CH];
  logic [PW-1:0]               fill_w    [NUM_CH];
  logic [NUM_CH-1:0]           avail_w;
  logic [NUM_CH-1:0]           room_w;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign fill_w[g]  = wr_ptr_r[g] - rd_ptr_r[g];
    assign avail_w[g] = cmt_ptr_r[g] != rd_ptr_r[g];
    assign room_w[g]  = fill_w[g] <= ROOM_MAX;
  end

  // ----------------------------------------------------------------------------
  // input side
  // ----------------------------------------------------------------------------
  logic          in_ready_r;
  logic [CW-1:0] wr_idx;
  logic          ch_ok_w;
  logic          store_en;
  logic          bad_w;
  logic [PW-1:0] wr_cur;
  logic [PW-1:0] wr_nxt;
  logic          drop_evt;

  assign wr_idx   = in_beat.channel;
  assign ch_ok_w  = wr_idx <= LAST_CH;
  assign store_en = in_valid & in_ready_r & ch_ok_w;
  assign wr_cur   = wr_ptr_r[wr_idx];
  assign wr_nxt   = wr_cur + PW'(1);
  assign bad_w    = drop_r[wr_idx] | (|in_beat.error);
  assign drop_evt = store_en & in_beat.eop & bad_w;

  // ready is registered, so it falls once any segment has under two free words, which absorb the lag; a full
  // channel stalls all inputs, traded for a ready that comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ready_r <= 1'b0;
    end else begin
      in_ready_r <= &room_w;
    end
  end

  always_ff @(posedge pclk) begin
    if (store_en) begin
      mem[seg_addr(wr_idx, wr_cur)] <= in_beat;
    end
  end

  // uncommitted words sit between cmt and wr; a bad packet rewinds wr to cmt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        wr_ptr_r[i]  <= '0;
        cmt_ptr_r[i] <= '0;
        drop_r[i]    <= 1'b0;
      end
    end else if (store_en) begin
      if (in_beat.eop) begin
        drop_r[wr_idx] <= 1'b0;
        if (bad_w) begin
          wr_ptr_r[wr_idx] <= cmt_ptr_r[wr_idx];
        end else begin
          wr_ptr_r[wr_idx]  <= wr_nxt;
          cmt_ptr_r[wr_idx] <= wr_nxt;
        end
      end else begin
        drop_r[wr_idx] <= bad_w;
        if (!bad_w) begin
          wr_ptr_r[wr_idx] <= wr_nxt;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // request path
  // ----------------------------------------------------------------------------
  msfifo_pkg::msfifo_rq_type   state_r;
  msfifo_pkg::msfifo_rq_type   state_nxt;
  msfifo_pkg::msfifo_beat_type mem_q;
  msfifo_pkg::msfifo_beat_type pipe_q;
  msfifo_pkg::msfifo_beat_type out_beat_r;
  logic                        out_valid_r;
  logic                        busy_r;
  logic                        hit_r;
  logic [CW-1:0]               lk_ch_r;
  logic                        req_en_w;
  logic [CW-1:0]               req_ch_w;
  logic                        accept_w;
  logic                        lk_hit_w;
  logic [PW-1:0]               rd_cur;
  logic                        miss_evt;

  // without the port, the strobe is held high and the channel held at zero
  assign req_en_w = (USE_REQUEST != 0) ? req_strobe : 1'b1;
  assign req_ch_w = (USE_REQUEST != 0) ? req_channel : '0;
  assign accept_w = (state_r == msfifo_pkg::RQ_IDLE) & req_en_w;
  assign lk_hit_w = (lk_ch_r <= LAST_CH) & avail_w[lk_ch_r];
  assign rd_cur   = rd_ptr_r[lk_ch_r];
  assign miss_evt = (state_r == msfifo_pkg::RQ_LOOK) & ~lk_hit_w;

  // accept -> look -> read -> load -> show gives the word three edges later
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      msfifo_pkg::RQ_IDLE: if (accept_w) state_nxt = msfifo_pkg::RQ_LOOK;
      msfifo_pkg::RQ_LOOK: state_nxt = msfifo_pkg::RQ_READ;
      msfifo_pkg::RQ_READ: state_nxt = msfifo_pkg::RQ_LOAD;
      msfifo_pkg::RQ_LOAD: state_nxt = msfifo_pkg::RQ_SHOW;
      msfifo_pkg::RQ_SHOW: if (out_ready | ~out_valid_r) state_nxt = msfifo_pkg::RQ_IDLE;
      default:             state_nxt = msfifo_pkg::RQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= msfifo_pkg::RQ_IDLE;
      busy_r  <= 1'b0;
      lk_ch_r <= '0;
      hit_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= state_nxt != msfifo_pkg::RQ_IDLE;
      if (accept_w) begin
        lk_ch_r <= req_ch_w;
      end
      if (state_r == msfifo_pkg::RQ_LOOK) begin
        hit_r <= lk_hit_w;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        rd_ptr_r[i] <= '0;
      end
    end else if ((state_r == msfifo_pkg::RQ_LOOK) && lk_hit_w) begin
      rd_ptr_r[lk_ch_r] <= rd_cur + PW'(1);
    end
  end

  // plain registered read so the array maps onto block memory
  always_ff @(posedge pclk) begin
    mem_q <= mem[seg_addr(lk_ch_r, rd_cur)];
    if (state_r == msfifo_pkg::RQ_READ) begin
      pipe_q <= mem_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_r <= 1'b0;
      out_beat_r  <= '0;
    end else if (state_r == msfifo_pkg::RQ_LOAD) begin
      out_valid_r <= hit_r;
      if (hit_r) begin
        out_beat_r <= pipe_q;
      end
    end else if ((state_r == msfifo_pkg::RQ_SHOW) && out_ready) begin
      out_valid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // fill-level port
  // ----------------------------------------------------------------------------
  logic [31:0] fill_rdata_r;
  logic        fill_rvalid_r;
  logic [31:0] fill_sel_w;

  assign fill_sel_w = (fill_channel <= LAST_CH) ? widen(fill_w[fill_channel]) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_rdata_r  <= '0;
      fill_rvalid_r <= 1'b0;
    end else begin
      fill_rvalid_r <= fill_read;
      if (fill_read) begin
        fill_rdata_r <= fill_sel_w;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // threshold status, round-robin
  // ----------------------------------------------------------------------------
  logic [PW-1:0]               af1_r;
  logic [PW-1:0]               af2_r;
  logic [PW-1:0]               ae1_r;
  logic [PW-1:0]               ae2_r;
  logic [CW-1:0]               rr_r;
  logic [CW-1:0]               rr_nxt;
  logic [PW-1:0]               rr_fill;
  logic [1:0]                  af_bits;
  logic [1:0]                  ae_bits;
  msfifo_pkg::msfifo_stat_type af_stat_r;
  msfifo_pkg::msfifo_stat_type ae_stat_r;

  assign rr_nxt  = (rr_r == LAST_CH) ? '0 : rr_r + CW'(1);
  assign rr_fill = fill_w[rr_r];
  assign af_bits = {rr_fill >= af2_r, rr_fill >= af1_r};
  assign ae_bits = {rr_fill <= ae2_r, rr_fill <= ae1_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr_r      <= '0;
      af_stat_r <= '0;
      ae_stat_r <= '0;
    end else begin
      rr_r      <= rr_nxt;
      af_stat_r <= '{valid: 1'b1, channel: rr_r, data: af_bits};
      ae_stat_r <= '{valid: 1'b1, channel: rr_r, data: ae_bits};
    end
  end

  // ----------------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------------
  logic [31:0]                   prdata_r;
  logic                          pready_r;
  logic                          pslverr_r;
  logic [msfifo_pkg::INT_W-1:0]  int_stat_r;
  logic [msfifo_pkg::INT_W-1:0]  int_en_r;
  logic [msfifo_pkg::INT_W-1:0]  int_evt;
  logic [msfifo_pkg::INT_W-1:0]  int_clr;
  logic [msfifo_pkg::INT_W-1:0]  int_stat_nxt;
  logic [31:0]                   drop_cnt_r;
  logic                          irq_r;
  logic                          setup_w;
  logic                          wr_w;
  logic                          hit_af1;
  logic                          hit_af2;
  logic                          hit_ae1;
  logic                          hit_ae2;
  logic                          hit_st;
  logic                          hit_clr;
  logic                          hit_en;
  logic                          hit_cnt;
  logic                          mapped_w;
  logic [31:0]                   rd_mux;

  assign setup_w  = psel & ~penable;
  assign wr_w     = psel & penable & pready_r & pwrite;
  assign hit_af1  = paddr == msfifo_pkg::OFF_AF1;
  assign hit_af2  = paddr == msfifo_pkg::OFF_AF2;
  assign hit_ae1  = paddr == msfifo_pkg::OFF_AE1;
  assign hit_ae2  = paddr == msfifo_pkg::OFF_AE2;
  assign hit_st   = paddr == msfifo_pkg::OFF_INT_STAT;
  assign hit_clr  = paddr == msfifo_pkg::OFF_INT_CLR;
  assign hit_en   = paddr == msfifo_pkg::OFF_INT_EN;
  assign hit_cnt  = paddr == msfifo_pkg::OFF_DROP_CNT;
  assign mapped_w = hit_af1 | hit_af2 | hit_ae1 | hit_ae2 | hit_st | hit_clr | hit_en | hit_cnt;

  assign rd_mux = hit_af1 ? widen(af1_r) :
                  hit_af2 ? widen(af2_r) :
                  hit_ae1 ? widen(ae1_r) :
                  hit_ae2 ? widen(ae2_r) :
                  hit_st  ? {{(32-msfifo_pkg::INT_W){1'b0}}, int_stat_r} :
                  hit_en  ? {{(32-msfifo_pkg::INT_W){1'b0}}, int_en_r} :
                  hit_cnt ? drop_cnt_r : 32'h0000_0000;

  assign int_evt[msfifo_pkg::INT_DROP] = drop_evt;
  assign int_evt[msfifo_pkg::INT_MISS] = miss_evt;
  assign int_evt[msfifo_pkg::INT_AF]   = af_bits[0];
  assign int_clr      = (wr_w && hit_clr) ? pwdata[msfifo_pkg::INT_W-1:0] : '0;
  // set is or-ed in after the clear so an event in the clearing cycle survives
  assign int_stat_nxt = (int_stat_r & ~int_clr) | int_evt;

  // every access answers after exactly one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w & ~mapped_w;
      if (setup_w) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      af1_r    <= msfifo_pkg::AF1_RST[PW-1:0];
      af2_r    <= msfifo_pkg::AF2_RST[PW-1:0];
      ae1_r    <= msfifo_pkg::AE1_RST[PW-1:0];
      ae2_r    <= msfifo_pkg::AE2_RST[PW-1:0];
      int_en_r <= msfifo_pkg::INT_EN_RST;
    end else if (wr_w) begin
      if (hit_af1) af1_r <= pwdata[PW-1:0];
      if (hit_af2) af2_r <= pwdata[PW-1:0];
      if (hit_ae1) ae1_r <= pwdata[PW-1:0];
      if (hit_ae2) ae2_r <= pwdata[PW-1:0];
      if (hit_en)  int_en_r <= pwdata[msfifo_pkg::INT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_r <= '0;
      irq_r      <= 1'b0;
      drop_cnt_r <= '0;
    end else begin
      int_stat_r <= int_stat_nxt;
      irq_r      <= |(int_stat_nxt & int_en_r);
      if (drop_evt) begin
        drop_cnt_r <= drop_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign in_ready    = in_ready_r;
  assign out_valid   = out_valid_r;
  assign out_beat    = out_beat_r;
  assign req_busy    = busy_r;
  assign fill_rdata  = fill_rdata_r;
  assign fill_rvalid = fill_rvalid_r;
  assign af_stat     = af_stat_r;
  assign ae_stat     = ae_stat_r;
  assign irq         = irq_r;

endmodule

//--- sim/msfifo_sink_model.sv
// stream consumer on the fifo output; can stall.
// assumes all inputs synchronous to pclk; stall comes from the bench.
module msfifo_sink_model (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        stall,
  input  wire logic                        out_valid,
  input  wire msfifo_pkg::msfifo_beat_type out_beat,
  output logic                             out_ready,
  output logic [31:0]                      taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------------
  // consumer
  // ----------------------------------------------------------------------------
  // registered ready: a stall lands one edge late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
      taken     <= 32'h0;
    end else begin
      out_ready <= ~stall;
      if (out_valid && out_ready && out_beat.error == '0) begin
        taken <= taken + 32'h1;
      end
    end
  end
endmodule

//--- sim/msfifo_checker.sv
// port checks for msfifo_top, bound in after the module.
// assumes one clock pclk and asynchronous active-low presetn.
module msfifo_checker #(
  parameter int NUM_CH = 16
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        out_valid,
  input wire msfifo_pkg::msfifo_beat_type out_beat,
  input wire logic                        out_ready,
  input wire logic                        req_strobe,
  input wire logic                        req_busy,
  input wire logic                        fill_read,
  input wire logic                        fill_rvalid,
  input wire msfifo_pkg::msfifo_stat_type af_stat,
  input wire msfifo_pkg::msfifo_stat_type ae_stat
);
  localparam logic [3:0] CH_LAST = 4'(NUM_CH - 1);
  logic accept;
  assign accept = req_strobe & ~req_busy;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  chk_apb_answer: assert property (psel && !penable |=> pready && penable)
    else $error("no apb answer after setup");
  chk_apb_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("stray pslverr");
  chk_fill_latency: assert property (1'b1 |=> fill_rvalid == $past(fill_read))
    else $error("fill valid late");
  chk_out_latency: assert property ($rose(out_valid) |-> $past(accept, 4))
    else $error("output latency not three");
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
    else $error("output not held");
  chk_out_one_req: assert property (out_valid |-> req_busy)
    else $error("output without request");
  chk_out_no_err: assert property (out_valid |-> out_beat.error == '0)
    else $error("errored word forwarded");
  chk_rr_step: assert property (af_stat.valid && $past(af_stat.valid) |->
    af_stat.channel == (($past(af_stat.channel) == CH_LAST) ? 4'h0 : $past(af_stat.channel) + 4'h1))
    else $error("status channel skipped");
  chk_stat_pair: assert property (ae_stat.valid == af_stat.valid && ae_stat.channel == af_stat.channel)
    else $error("status outputs out of step");
endmodule

bind msfifo_top msfifo_checker #(.NUM_CH(NUM_CH)) u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .out_valid, .out_beat, .out_ready, .req_strobe, .req_busy, .fill_read, .fill_rvalid, .af_stat, .ae_stat);

//--- sim/msfifo_top_tb.sv
// self-checking bench for msfifo_top.
// assumes the sink model on the output and the bound checker.
module msfifo_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]                  paddr = 8'h0;
  logic [31:0]                 pwdata = 32'h0, prdata, fill_rdata, taken;
  logic                        pready, pslverr, in_valid = 0, in_ready, out_valid, out_ready, irq;
  logic                        req_strobe = 0, req_busy, fill_read = 0, fill_rvalid, stall = 0;
  logic [3:0]                  req_channel = 4'h0, fill_channel = 4'h0;
  msfifo_pkg::msfifo_beat_type in_beat = '0, out_beat;
  msfifo_pkg::msfifo_stat_type af_stat, ae_stat;
  int                          n_fail = 0, comparisons = 0;

  always #2.5 pclk = ~pclk;
  msfifo_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .in_valid, .in_beat, .in_ready, .out_valid, .out_beat, .out_ready, .req_strobe, .req_channel, .req_busy,
    .fill_read, .fill_channel, .fill_rdata, .fill_rvalid, .af_stat, .ae_stat, .irq);
  msfifo_sink_model sink (.pclk, .presetn, .stall, .out_valid, .out_beat, .out_ready, .taken);

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic push(input logic [3:0] ch, input logic [31:0] d, input logic eop, input logic err);
    in_valid <= 1'b1;
    in_beat <= '{d, ch, 1'b0, eop, err};
    do @(posedge pclk); while (in_ready !== 1'b1);
  endtask
  task automatic idle();
    in_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rq(input logic [3:0] ch, input logic hit, input logic [31:0] d);
    req_strobe <= 1'b1;
    req_channel <= ch;
    @(posedge pclk);
    req_strobe <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    cmp("out_valid", {31'h0, hit}, {31'h0, out_valid});
    if (hit) cmp("out_data", d, out_beat.data);
    while (req_busy !== 1'b0) @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic fill(input logic [3:0] ch, input logic [31:0] exp);
    fill_read <= 1'b1;
    fill_channel <= ch;
    @(posedge pclk);
    fill_read <= 1'b0;
    @(negedge pclk);
    cmp("fill_rvalid", 32'h1, {31'h0, fill_rvalid});
    cmp("fill_level", exp, fill_rdata);
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    logic [31:0] rst [4];
    rst = '{msfifo_pkg::AF1_RST, msfifo_pkg::AF2_RST, msfifo_pkg::AE1_RST, msfifo_pkg::AE2_RST};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, q, e);
      cmp("thr_reset", rst[i], q);
    end
    apb(1'b1, msfifo_pkg::OFF_AF1, 32'h0000_0009, q, e);
    apb(1'b0, msfifo_pkg::OFF_AF1, 32'h0, q, e);
    cmp("af1_rw", 32'h0000_0009, q);
    apb(1'b0, 8'h20, 32'h0, q, e);
    cmp("unmapped_err", 32'h1, {31'h0, e});
  endtask
  // top channel, consumer stalled on the first word
  task automatic t_order();
    for (int i = 0; i < 3; i++) push(4'hf, 32'h0000_00a0 + i, i == 2, 1'b0);
    idle();
    fill(4'hf, 32'h3);
    stall <= 1'b1;
    fork
      rq(4'hf, 1'b1, 32'h0000_00a0);
      begin repeat (8) @(posedge pclk); stall <= 1'b0; end
    join
    rq(4'hf, 1'b1, 32'h0000_00a1);
    rq(4'hf, 1'b1, 32'h0000_00a2);
    rq(4'hf, 1'b0, 32'h0);
    cmp("words_taken", 32'h3, taken);
  endtask
  task automatic t_drop();
    push(4'h3, 32'h0000_00b0, 1'b0, 1'b0);
    push(4'h3, 32'h0000_00b1, 1'b0, 1'b1);
    push(4'h3, 32'h0000_00b2, 1'b1, 1'b0);
    idle();
    rq(4'h3, 1'b0, 32'h0);
    fill(4'h3, 32'h0);
  endtask
  task automatic t_partial();
    push(4'h7, 32'h0000_00c0, 1'b0, 1'b0);
    push(4'h7, 32'h0000_00c1, 1'b0, 1'b0);
    idle();
    rq(4'h7, 1'b0, 32'h0);
    fill(4'h7, 32'h2);
    do @(negedge pclk); while (af_stat.channel !== 4'h7);
    cmp("af_stat", 32'h0, {30'h0, af_stat.data});
    cmp("ae_stat", 32'h3, {30'h0, ae_stat.data});
    @(posedge pclk);
  endtask
  task automatic t_irq();
    logic [31:0] q;
    logic        e;
    apb(1'b0, msfifo_pkg::OFF_INT_STAT, 32'h0, q, e);
    cmp("int_stat", 32'h3, q);
    cmp("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, msfifo_pkg::OFF_INT_EN, 32'h3, q, e);
    @(negedge pclk);
    cmp("irq_on", 32'h1, {31'h0, irq});
    apb(1'b0, msfifo_pkg::OFF_DROP_CNT, 32'h0, q, e);
    cmp("drop_cnt", 32'h1, q);
    apb(1'b1, msfifo_pkg::OFF_INT_CLR, 32'h3, q, e);
    apb(1'b0, msfifo_pkg::OFF_INT_CLR, 32'h0, q, e);
    cmp("int_clr_read", 32'h0, q);
    apb(1'b0, msfifo_pkg::OFF_INT_STAT, 32'h0, q, e);
    cmp("int_cleared", 32'h0, q);
    @(negedge pclk);
    cmp("irq_off", 32'h0, {31'h0, irq});
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_order();
    t_drop();
    t_partial();
    t_irq();
    print_verdict();
  end
  // ends a hung run
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
endmodule
